// ==== include/cbi_params.svh ====
// cbi_params.svh: register offsets, field positions, reset values, vectors and status codes
// assumes it is included by the bus port modules, with cbi_pkg compiled first
`ifndef CBI_PARAMS_SVH
`define CBI_PARAMS_SVH
`define CBI_OFS_ADDR 5'h00
`define CBI_OFS_DATA 5'h04
`define CBI_OFS_CMD 5'h08
`define CBI_OFS_MASK 5'h0C
`define CBI_OFS_IRQ 5'h10
`define CBI_OFS_STAT 5'h14
`define CBI_PC_RST 16'h0000
`define CBI_VEC_TRAP 8'h24
`define CBI_VEC_HI 8'h3C
`define CBI_VEC_MID 8'h34
`define CBI_VEC_LO 8'h2C
`define CBI_VEC_GEN 8'h00
`define CBI_MSK_RST 3'h7
`define CBI_STS_HALT 2'h0
`define CBI_STS_WRITE 2'h1
`define CBI_STS_READ 2'h2
`define CBI_STS_FETCH 2'h3
`define CBI_MW_MSE 3
`define CBI_MW_HICLR 4
`define CBI_MW_SOE 6
`define CBI_MW_SOV 7
`define CBI_MW_IEV 8
`define CBI_MW_IEWE 9
`endif

// ==== include/cbi_pkg.sv ====
// cbi_pkg: state, command and interrupt types of the bus and interrupt port
// assumes nothing beyond a SystemVerilog compiler
package cbi_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01, ST_T1 = 5'h02, ST_T2 = 5'h04, ST_TW = 5'h08, ST_T3 = 5'h10
	} cbi_state_t;
	typedef enum logic [2:0] {
		CK_MRD = 3'h0, CK_MWR = 3'h1, CK_IORD = 3'h2, CK_IOWR = 3'h3, CK_FETCH = 3'h4,
		CK_HALT = 3'h5
	} cbi_kind_t;
	typedef enum logic [2:0] {
		SRC_TRAP = 3'h0, SRC_HI = 3'h1, SRC_MID = 3'h2, SRC_LO = 3'h3, SRC_GEN = 3'h4
	} cbi_src_t;
	typedef struct packed {
		logic take;
		cbi_src_t src;
		logic [7:0] vec;
	} cbi_take_t;
	typedef struct packed {
		logic trap;
		logic hi;
		logic mid;
		logic lo;
		logic gen;
	} cbi_irq_lines_t;
endpackage

// ==== hdl/cbi_sync3.sv ====
// cbi_sync3: three flip-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk_sys; output moves when stages two and three agree
`timescale 1ns/100ps
module cbi_sync3 import cbi_pkg::*; #(parameter int W = 1) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
	// s1 feeds s2 only, so metastability never reaches the agree test
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg ^ s3_reg));
		end
	end
	assign sync_out = out_reg;
endmodule // cbi_sync3

// ==== hdl/cbi_irq_ctrl.sv ====
// cbi_irq_ctrl: trigger capture, masking and fixed priority of the five interrupt inputs
// assumes synchronised lines and a sample strobe from the bus port
`timescale 1ns/100ps
`include "cbi_params.svh"
module cbi_irq_ctrl import cbi_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire cbi_irq_lines_t lines,
	input wire logic ie,
	input wire logic [2:0] mask,
	input wire logic sample,
	input wire logic clr_hi,
	output cbi_take_t take_o,
	output logic [2:0] pend_o
);
	logic trap_prev_reg, trap_edge_reg, hi_prev_reg, hi_latch_reg;
	cbi_take_t take_reg;
	cbi_src_t src_sel;
	logic [7:0] vec_sel;
	wire trap_rise = lines.trap & ~trap_prev_reg;
	wire hi_rise = lines.hi & ~hi_prev_reg;
	// a take in flight blocks a second one in the cycle before ie is cleared
	wire ie_eff = ie & ~take_reg.take;
	wire req_trap = trap_edge_reg & lines.trap;
	wire req_hi = hi_latch_reg & ~mask[2] & ie_eff;
	wire req_mid = lines.mid & ~mask[1] & ie_eff;
	wire req_lo = lines.lo & ~mask[0] & ie_eff;
	wire req_gen = lines.gen & ie_eff;
	wire any_req = req_trap | req_hi | req_mid | req_lo | req_gen;
	wire take_now = sample & any_req;
	assign src_sel = req_trap ? SRC_TRAP : req_hi ? SRC_HI : req_mid ? SRC_MID :
		req_lo ? SRC_LO : SRC_GEN;
	assign vec_sel = req_trap ? `CBI_VEC_TRAP : req_hi ? `CBI_VEC_HI : req_mid ? `CBI_VEC_MID :
		req_lo ? `CBI_VEC_LO : `CBI_VEC_GEN;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trap_prev_reg <= 1'b0;
			trap_edge_reg <= 1'b0;
			hi_prev_reg <= 1'b0;
			hi_latch_reg <= 1'b0;
			take_reg <= '0;
		end else begin
			trap_prev_reg <= lines.trap;
			hi_prev_reg <= lines.hi;
			// a new edge wins over the clear of the one being serviced
			if (trap_rise)
				trap_edge_reg <= 1'b1;
			else if (take_now && src_sel == SRC_TRAP)
				trap_edge_reg <= 1'b0;
			// the highest restart latches even while masked
			if (hi_rise)
				hi_latch_reg <= 1'b1;
			else if (clr_hi || (take_now && src_sel == SRC_HI))
				hi_latch_reg <= 1'b0;
			take_reg <= '{take: take_now, src: src_sel, vec: vec_sel};
		end
	end
	assign take_o = take_reg;
	assign pend_o = {hi_latch_reg, lines.mid, lines.lo};
	a_trap_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sample && req_trap |=> take_o.take && take_o.src == SRC_TRAP && take_o.vec == 8'h24)
		else $error("trap not taken first at its vector");
	a_hi_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hi_rise |=> pend_o[2])
		else $error("rising highest restart not held");
endmodule // cbi_irq_ctrl

// ==== hdl/cbi_port.sv ====
// cbi_port: pin-level bus cycles, hold, interrupts, reset and clock outputs of an 8-bit cpu
// assumes software drives the core over Avalon-MM; pins resolve from the _oe outputs outside
//
// Functional notes
// - low address on shared lines in first state, then data in states two and three.
// - upper address on its own lines, floated in hold, halt and reset.
// - latch strobe pulses in the first state, never floated; captured on its fall.
// - read strobe low marks a read with the data lines free.
// - write strobe low while write data is valid through its trailing edge.
// - ready sampled in read and write cycles; low adds whole clock cycles.
// - hold request releases the bus after the current transfer; bus regained after removal.
// - during hold acknowledge address, data, strobes and io select float.
// - hold acknowledge rises half or one clock before release; bus retaken half a clock after drop.
// - general request sampled at instruction end and during hold and halt.
// - accepted general request stops the pc and issues an interrupt acknowledge.
// - interrupt acknowledge replaces the read strobe in the following fetch cycle.
// - interrupt enable set and cleared by software, cleared by reset and acceptance.
// - restart inputs share sampling, insert restarts and each is masked by software.
// - trap ignores masks and enable and has the highest priority.
// - trap edge plus level, highest restart latched edge, others high levels.
// - fixed priority trap first, general last; trap 24H, middle 34H, lowest 2CH.
// - pc saved before branching to any vector.
// - reset zeroes pc, clears enable and hold acknowledge, floats bus and controls.
// - reset output follows reset, synchronised, whole clock periods.
// - processor clock is the input clock halved and driven out.
// - mask read returns the serial input at bit 7; mask write sets serial output.
`timescale 1ns/100ps
`include "cbi_params.svh"
module cbi_port import cbi_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] ad_i,
	output logic [7:0] ad_o,
	output logic ad_oe,
	output logic [7:0] addr_high,
	output logic addr_high_oe,
	output logic ale,
	output logic rd_n,
	output logic rd_oe,
	output logic wr_n,
	output logic wr_oe,
	output logic io_m,
	output logic io_m_oe,
	output logic cycle_status0,
	output logic cycle_status1,
	input wire logic ready,
	input wire logic hold_req,
	output logic hold_ack,
	input wire logic trap_in,
	input wire logic restart_hi,
	input wire logic restart_mid,
	input wire logic restart_lo,
	input wire logic general_irq,
	output logic irq_ack_n,
	output logic reset_out,
	output logic clk_out,
	input wire logic serial_in_line,
	output logic serial_out_line
);
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			be_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
	endfunction

	cbi_state_t st_reg, st_next;
	cbi_kind_t kind_reg;
	cbi_take_t take;
	logic phase_reg, reset_out_reg, launched_reg, hold_ack_reg, float_reg, halted_reg;
	logic ack_pend_reg, ie_reg, sod_reg, take_v_reg, rd_ack_reg;
	logic is_wr_reg, is_ack_reg, io_cyc_reg;
	logic [1:0] sts_reg;
	logic [2:0] mask_reg, pend;
	logic [7:0] data_reg;
	logic [11:0] take_info_reg;
	logic [15:0] addr_reg, pc_reg, ret_pc_reg, cur_addr_reg;
	logic [31:0] rdata_reg, rmux;
	logic [15:0] pins_s;

	cbi_sync3 #(.W(16)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({ad_i, ready, hold_req, trap_in, restart_hi, restart_mid, restart_lo,
			general_irq, serial_in_line}),
		.sync_out(pins_s)
	);
	wire [7:0] ad_s = pins_s[15:8];
	wire ready_s = pins_s[7];
	wire hold_s = pins_s[6];
	wire si_s = pins_s[0];

	// register decode
	wire sel_addr = avs_address == `CBI_OFS_ADDR;
	wire sel_data = avs_address == `CBI_OFS_DATA;
	wire sel_cmd = avs_address == `CBI_OFS_CMD;
	wire sel_mask = avs_address == `CBI_OFS_MASK;
	wire sel_irq = avs_address == `CBI_OFS_IRQ;
	wire sel_stat = avs_address == `CBI_OFS_STAT;
	wire [31:0] wd_m = be_merge(rmux, avs_writedata, avs_byteenable);
	wire wr_b0 = avs_write & avs_byteenable[0];
	wire wr_cmd = wr_b0 & sel_cmd;
	wire wr_mask = wr_b0 & sel_mask;
	wire wr_irq = wr_b0 & sel_irq;
	wire [2:0] cmd_code = avs_writedata[2:0];
	wire cmd_bus = cmd_code <= CK_FETCH;
	wire cmd_halt = cmd_code == CK_HALT;

	// processor clock is half of clk_sys; tick marks its last clk_sys cycle
	wire tick = phase_reg;
	wire st_idle = st_reg == ST_IDLE;
	wire in_t1 = st_reg == ST_T1;
	wire in_strobe = (st_reg == ST_T2) | (st_reg == ST_TW) | (st_reg == ST_T3);
	wire cyc_end = (st_reg == ST_T3) & tick;
	// a pending hold beats a new cycle so the bus is given up between transfers
	wire start = wr_cmd & cmd_bus & ~launched_reg & st_idle & tick & ~hold_s & ~hold_ack_reg &
		~float_reg & ~reset_out_reg & ~halted_reg;
	wire drive = ~float_reg & ~reset_out_reg;
	wire drive_nh = drive & ~halted_reg;
	wire sample = wr_irq | hold_ack_reg | halted_reg;
	wire [7:0] take_vec = take.vec;

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			ST_IDLE: if (start) st_next = ST_T1;
			ST_T1: if (tick) st_next = ST_T2;
			ST_T2: if (tick) st_next = ready_s ? ST_T3 : ST_TW;
			ST_TW: if (tick && ready_s) st_next = ST_T3;
			ST_T3: if (tick) st_next = ST_IDLE;
			default: st_next = ST_IDLE;
		endcase
	end

	assign rmux = sel_addr ? {16'h0000, addr_reg} :
		sel_data ? {24'h000000, data_reg} :
		sel_cmd ? {28'h0000000, launched_reg, kind_reg} :
		sel_mask ? {24'h000000, si_s, pend, ie_reg, mask_reg} :
		sel_irq ? {ret_pc_reg, 3'h0, take_v_reg, take_info_reg} :
		sel_stat ? {pc_reg, 12'h000, ack_pend_reg, reset_out_reg, halted_reg, hold_ack_reg} :
		32'h00000000;

	cbi_irq_ctrl u_irq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.lines('{trap: pins_s[5], hi: pins_s[4], mid: pins_s[3], lo: pins_s[2], gen: pins_s[1]}),
		.ie(ie_reg),
		.mask(mask_reg),
		.sample(sample),
		.clr_hi(wr_mask & avs_writedata[`CBI_MW_HICLR]),
		.take_o(take),
		.pend_o(pend)
	);

	// clock divider, reset output and hold handshake
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 1'b0;
			reset_out_reg <= 1'b1;
			hold_ack_reg <= 1'b0;
			float_reg <= 1'b0;
		end else begin
			phase_reg <= ~phase_reg;
			if (tick)
				reset_out_reg <= 1'b0;
			if (hold_s && st_idle)
				hold_ack_reg <= 1'b1;
			else if (!hold_s)
				hold_ack_reg <= 1'b0;
			// floats at the next tick after acknowledge, half or one processor clock later; returns half a clock after its drop
			if (!hold_ack_reg)
				float_reg <= 1'b0;
			else if (tick)
				float_reg <= 1'b1;
		end
	end

	// bus cycle sequencer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_IDLE;
			kind_reg <= CK_MRD;
			launched_reg <= 1'b0;
			is_wr_reg <= 1'b0;
			is_ack_reg <= 1'b0;
			io_cyc_reg <= 1'b0;
			sts_reg <= `CBI_STS_READ;
			cur_addr_reg <= `CBI_PC_RST;
			data_reg <= 8'h00;
			addr_reg <= 16'h0000;
		end else begin
			st_reg <= st_next;
			if (start) begin
				kind_reg <= cbi_kind_t'(cmd_code);
				launched_reg <= 1'b1;
				is_wr_reg <= cmd_code == CK_MWR || cmd_code == CK_IOWR;
				is_ack_reg <= cmd_code == CK_FETCH && ack_pend_reg;
				io_cyc_reg <= cmd_code == CK_IORD || cmd_code == CK_IOWR ||
					(cmd_code == CK_FETCH && ack_pend_reg);
				sts_reg <= cmd_code == CK_FETCH ? `CBI_STS_FETCH :
					(cmd_code == CK_MWR || cmd_code == CK_IOWR) ? `CBI_STS_WRITE :
					`CBI_STS_READ;
				// io cycles repeat the 8-bit port number on both halves
				cur_addr_reg <= cmd_code == CK_FETCH ? pc_reg :
					(cmd_code == CK_IORD || cmd_code == CK_IOWR) ?
					{addr_reg[7:0], addr_reg[7:0]} : addr_reg;
			end else if (cyc_end) begin
				launched_reg <= 1'b0;
			end
			// zero-wait reads only see data that was stable well before the strobe
			if (cyc_end && !is_wr_reg)
				data_reg <= ad_s;
			else if (avs_write && sel_data)
				data_reg <= wd_m[7:0];
			if (avs_write && sel_addr)
				addr_reg <= wd_m[15:0];
		end
	end

	// pc, interrupt enable, masks, serial output and interrupt capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= `CBI_PC_RST;
			ret_pc_reg <= `CBI_PC_RST;
			ie_reg <= 1'b0;
			mask_reg <= `CBI_MSK_RST;
			sod_reg <= 1'b0;
			halted_reg <= 1'b0;
			ack_pend_reg <= 1'b0;
			take_v_reg <= 1'b0;
			take_info_reg <= 12'h000;
		end else begin
			if (take.take && take.src != SRC_GEN) begin
				ret_pc_reg <= pc_reg;
				pc_reg <= {8'h00, take_vec};
			end else if (cyc_end && kind_reg == CK_FETCH && !is_ack_reg) begin
				pc_reg <= pc_reg + 16'h0001;
			end else if (avs_write && sel_stat) begin
				pc_reg <= wd_m[31:16];
			end
			if (take.take)
				ie_reg <= 1'b0;
			else if (wr_mask && avs_writedata[`CBI_MW_IEWE])
				ie_reg <= avs_writedata[`CBI_MW_IEV];
			if (wr_mask && avs_writedata[`CBI_MW_MSE])
				mask_reg <= avs_writedata[2:0];
			if (wr_mask && avs_writedata[`CBI_MW_SOE])
				sod_reg <= avs_writedata[`CBI_MW_SOV];
			if (take.take)
				halted_reg <= 1'b0;
			else if (wr_cmd && cmd_halt && st_idle)
				halted_reg <= 1'b1;
			// the acknowledge fetch leaves the pc alone, the inserted instruction steers it
			if (take.take && take.src == SRC_GEN)
				ack_pend_reg <= 1'b1;
			else if (cyc_end && is_ack_reg)
				ack_pend_reg <= 1'b0;
			if (take.take) begin
				take_v_reg <= 1'b1;
				take_info_reg <= {take.src, 1'b0, take.vec};
			end else if (rd_ack_reg && sel_irq) begin
				take_v_reg <= 1'b0;
			end
		end
	end

	// register reads take one wait cycle so read data comes from a flip-flop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			rd_ack_reg <= avs_read & ~rd_ack_reg;
			if (avs_read && !rd_ack_reg)
				rdata_reg <= rmux;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = (avs_read & ~rd_ack_reg) | (wr_cmd & cmd_bus & ~cyc_end);
	assign ale = in_t1;
	assign ad_o = in_t1 ? cur_addr_reg[7:0] : data_reg;
	assign ad_oe = drive_nh & (in_t1 | (in_strobe & is_wr_reg));
	assign addr_high = cur_addr_reg[15:8];
	assign addr_high_oe = drive_nh;
	assign rd_n = ~(in_strobe & ~is_wr_reg & ~is_ack_reg);
	assign rd_oe = drive_nh;
	assign wr_n = ~(in_strobe & is_wr_reg);
	assign wr_oe = drive_nh;
	assign io_m = io_cyc_reg;
	assign io_m_oe = drive_nh;
	assign {cycle_status1, cycle_status0} = halted_reg ? `CBI_STS_HALT : sts_reg;
	assign irq_ack_n = ~(in_strobe & is_ack_reg);
	assign hold_ack = hold_ack_reg;
	assign reset_out = reset_out_reg;
	assign clk_out = phase_reg;
	assign serial_out_line = sod_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ale_two_clk: assert property ($rose(ale) |-> ale ##1 ale ##1 !ale)
		else $error("latch strobe not one processor clock");
	a_addr_first: assert property (ale |-> ad_oe && ad_o == cur_addr_reg[7:0])
		else $error("low address missing in first state");
	a_rd_len: assert property ($fell(rd_n) |-> !rd_n [*4])
		else $error("read strobe shorter than two clocks");
	a_wr_data: assert property (!wr_n |-> ad_oe && ad_o == data_reg)
		else $error("write data not valid under strobe");
	a_ready_wait: assert property (st_reg == ST_T2 && tick && !ready_s |=> st_reg == ST_TW)
		else $error("ready low did not add a wait state");
	a_hold_float: assert property ($rose(hold_ack) |-> ##[1:2] (!ad_oe && !rd_oe && !wr_oe &&
		!io_m_oe && !addr_high_oe))
		else $error("bus not floated after hold acknowledge");
	a_hold_retake: assert property ($fell(hold_ack) && !halted_reg |=> !float_reg)
		else $error("bus not retaken half a clock after hold drop");
	a_ie_cleared: assert property (take.take |=> !ie_reg ##1 !take.take)
		else $error("enable not cleared on acceptance");
	a_ack_not_rd: assert property (!irq_ack_n |-> rd_n && kind_reg == CK_FETCH)
		else $error("acknowledge overlaps read strobe");
	a_pc_held: assert property (cyc_end && is_ack_reg && !take.take |=> pc_reg == $past(pc_reg))
		else $error("pc moved during acknowledge fetch");
	a_vec_branch: assert property (take.take && take.src != SRC_GEN |=>
		pc_reg == {8'h00, $past(take_vec)} && ret_pc_reg == $past(pc_reg))
		else $error("vector branch or saved pc wrong");
	a_rst_whole: assert property ($fell(reset_out) |-> !clk_out)
		else $error("reset output not aligned to clock");
endmodule // cbi_port

// ==== test/cbi_bus_model.sv ====
// cbi_bus_model: memory and port partner on the pin side of cbi_port
// assumes the bench passes ad_o and the enables straight from the port
`timescale 1ns/100ps
module cbi_bus_model import cbi_pkg::*; (
	input wire logic clk_sys,
	input wire logic [7:0] ad_o,
	input wire logic ad_oe,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic rd_oe,
	input wire logic wr_n,
	input wire logic wr_oe,
	input wire logic irq_ack_n,
	input wire logic [7:0] stall,
	output logic [7:0] ad_i,
	output logic ready
);
	logic [7:0] mem [256];
	logic [7:0] lat_reg = 8'h00;
	logic [7:0] flt_reg = 8'h00;
	logic [7:0] cnt_reg = 8'h00;
	logic armed_reg = 1'b0;
	wire rd_en = rd_oe && rd_n === 1'b0;
	wire ack_en = irq_ack_n === 1'b0;
	// released lines show a moving pattern, so stale data never passes
	assign ad_i = ad_oe ? ad_o : ack_en ? 8'hFF : rd_en ? mem[lat_reg] : flt_reg;
	// slow mode: ready low outside cycles, so the synchronised view is low at the end of T2
	assign ready = stall == 8'h00 || (armed_reg && !ale && cnt_reg == 8'h00);
	initial foreach (mem[i]) mem[i] = 8'h00;
	always @(negedge clk_sys) begin
		flt_reg <= flt_reg + 8'h5B;
		if (ale === 1'b1) lat_reg <= ad_i;
		if (ale === 1'b1) armed_reg <= 1'b1;
		else if (rd_n !== 1'b0 && wr_n !== 1'b0 && irq_ack_n !== 1'b0) armed_reg <= 1'b0;
		if (ale === 1'b1) cnt_reg <= stall;
		else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
		if (wr_oe && wr_n === 1'b0) mem[lat_reg] <= ad_i;
	end
endmodule // cbi_bus_model

// ==== test/testbench.sv ====
// testbench: register-driven checks of cbi_port against a pin-side partner
// assumes cbi_pkg compiled first; pins sampled on the falling clock edge, serial_out_line just after a rising one
`timescale 1ns/100ps
`include "cbi_params.svh"
module testbench import cbi_pkg::*; ;
	logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [7:0] ad_i, ad_o, addr_high, stall, ad_seen, ah_seen;
	logic ad_oe, addr_high_oe, ale, rd_n, rd_oe, wr_n, wr_oe, io_m, io_m_oe, io_seen, cs, b;
	logic cycle_status0, cycle_status1, ready, hold_req, hold_ack, trap_in, restart_hi;
	logic restart_mid, restart_lo, general_irq, irq_ack_n, reset_out, clk_out;
	logic serial_in_line, serial_out_line;
	logic [1:0] st_seen;
	int mismatches, n_tests, ack_cnt, rd_cnt, seed;
	cbi_port dut_u (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .ad_i, .ad_o, .ad_oe, .addr_high,
		.addr_high_oe, .ale, .rd_n, .rd_oe, .wr_n, .wr_oe, .io_m, .io_m_oe, .cycle_status0,
		.cycle_status1, .ready, .hold_req, .hold_ack, .trap_in, .restart_hi, .restart_mid,
		.restart_lo, .general_irq, .irq_ack_n, .reset_out, .clk_out, .serial_in_line,
		.serial_out_line);
	cbi_bus_model pm_u (.clk_sys, .ad_o, .ad_oe, .ale, .rd_n, .rd_oe, .wr_n, .wr_oe,
		.irq_ack_n, .stall, .ad_i, .ready);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) begin
		if (ale === 1'b1) begin
			st_seen <= {cycle_status1, cycle_status0};
			io_seen <= io_m;
			ad_seen <= ad_o;
			ah_seen <= addr_high;
		end
		if (irq_ack_n === 1'b0) ack_cnt <= ack_cnt + 1;
		if (rd_oe === 1'b1 && rd_n === 1'b0) rd_cnt <= rd_cnt + 1;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
		end
	endtask
	// request held until waitrequest is seen low at a falling edge
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] r);
		logic wt;
		int g;
		wt = 1'b1;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		for (g = 0; g < 3000 && wt !== 1'b0; g++) begin
			@(negedge clk_sys);
			wt = avs_waitrequest;
			r = avs_readdata;
			@(posedge clk_sys);
		end
		if (wt !== 1'b0) chk("waitrequest", 0, wt);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
		logic [31:0] r;
		av(1'b1, a, d, be, r);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] r);
		av(1'b0, a, 32'h0, 4'hF, r);
	endtask
	task automatic wait_on(input logic sel, input logic v, input string what);
		logic s;
		int g;
		s = ~v;
		for (g = 0; g < 40 && s !== v; g++) begin
			@(negedge clk_sys);
			s = sel ? hold_ack : reset_out;
			@(posedge clk_sys);
		end
		chk(what, v, s);
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("reset_out held", 1, reset_out);
		chk("enables in reset", 0, {ad_oe, addr_high_oe, rd_oe, wr_oe, io_m_oe, hold_ack});
		@(posedge clk_sys);
		rst_n <= 1'b1;
		wait_on(1'b0, 1'b0, "reset_out release");
		rd(`CBI_OFS_MASK, q);
		chk("mask reset", 4'h7, q[3:0]);
		rd(`CBI_OFS_STAT, q);
		chk("pc reset", 0, q[31:16]);
	endtask
	function automatic logic [7:0] vec_of(input int s);
		case (s)
			0: return 8'h24;
			1: return 8'h3C;
			2: return 8'h34;
			3: return 8'h2C;
			default: return 8'h00;
		endcase
	endfunction
	task automatic bus_kinds;
		int ks [5] = '{1, 0, 3, 2, 4};
		logic [15:0] a;
		logic [7:0] d;
		int k;
		foreach (ks[i]) begin
			k = ks[i];
			if (k != 0) begin
				a = 16'($urandom);
				d = 8'($urandom);
				wr(`CBI_OFS_ADDR, {16'h0, a});
				wr(`CBI_OFS_DATA, {24'h0, d});
			end
			stall <= (($urandom % 2) || k == 0) ? 8'h06 : 8'h00;
			wr(`CBI_OFS_CMD, k);
			chk("status", k == 4 ? 3 : k % 2 ? 1 : 2, st_seen);
			chk("io select", k == 2 || k == 3, io_seen);
			if (k < 2) chk("low addr", a[7:0], ad_seen);
			if (k < 2) chk("high addr", a[15:8], ah_seen);
			if (k == 1) chk("written byte", d, pm_u.mem[a[7:0]]);
			if (k == 0) rd(`CBI_OFS_DATA, q);
			if (k == 0) chk("read byte", d, q[7:0]);
		end
	endtask
	// src 7: no take expected
	task automatic irq_case(input logic [4:0] lines, input logic [31:0] mw, input int src);
		logic [15:0] pc;
		logic [31:0] m;
		int n, na;
		pc = 16'($urandom);
		wr(`CBI_OFS_STAT, {pc, 16'h0});
		wr(`CBI_OFS_MASK, mw);
		{trap_in, restart_hi, restart_mid, restart_lo, general_irq} <= lines;
		repeat (8) @(posedge clk_sys);
		wr(`CBI_OFS_IRQ, 32'h1);
		repeat (3) @(posedge clk_sys);
		rd(`CBI_OFS_IRQ, q);
		rd(`CBI_OFS_MASK, m);
		chk("take valid", src != 7, q[12]);
		if (src == 7) chk("edge latch", lines[3], m[6]);
		if (src != 7) begin
			chk("source", src, q[11:9]);
			chk("vector", vec_of(src), q[7:0]);
			chk("enable cleared", 0, m[3]);
			rd(`CBI_OFS_STAT, m);
		end
		if (src < 4) begin
			chk("saved pc", pc, q[31:16]);
			chk("pc at vector", vec_of(src), m[31:16]);
		end
		if (src == 4) begin
			chk("pc held", pc, m[31:16]);
			n = rd_cnt;
			na = ack_cnt;
			wr(`CBI_OFS_CMD, 32'h4);
			chk("ack strobe", 1, ack_cnt > na);
			chk("read strobe idle", n, rd_cnt);
		end
		{trap_in, restart_hi, restart_mid, restart_lo, general_irq} <= 5'h00;
		wr(`CBI_OFS_MASK, 32'h10);
		repeat (8) @(posedge clk_sys);
		rd(`CBI_OFS_IRQ, q);
	endtask
	initial begin
		rst_n = 1'b0;
		{trap_in, restart_hi, restart_mid, restart_lo, general_irq, hold_req} = 6'h00;
		{serial_in_line, avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		stall = 8'h00;
		{mismatches, n_tests, ack_cnt, rd_cnt} = '0;
		seed = $urandom(24);
		do_reset;
		@(negedge clk_sys);
		cs = clk_out;
		@(negedge clk_sys);
		chk("clk_out half rate", !cs, clk_out);
		@(posedge clk_sys);
		bus_kinds;
		wr(`CBI_OFS_DATA, 32'hA5);
		wr(`CBI_OFS_DATA, 32'h5A, 4'h0);
		rd(`CBI_OFS_DATA, q);
		chk("data byteenable", 8'hA5, q[7:0]);
		rd(5'h18, q);
		chk("unmapped read", 0, q);
		wr(5'h1C, $urandom);
		irq_case(5'b10000, 32'h20F, 0);
		irq_case(5'b01000, 32'h308, 1);
		irq_case(5'b00110, 32'h308, 2);
		irq_case(5'b00110, 32'h30A, 3);
		irq_case(5'b11111, 32'h308, 0);
		irq_case(5'b00001, 32'h308, 4);
		irq_case(5'b00010, 32'h20F, 7);
		irq_case(5'b01000, 32'h20F, 7);
		for (int i = 0; i < 2; i++) begin
			b = 1'($urandom);
			serial_in_line <= b;
			wr(`CBI_OFS_MASK, {24'h0, !b, 7'h40});
			repeat (6) @(posedge clk_sys);
			rd(`CBI_OFS_MASK, q);
			chk("serial in", b, q[7]);
			chk("serial out", !b, serial_out_line);
		end
		wr(`CBI_OFS_MASK, 32'h308);
		hold_req <= 1'b1;
		wait_on(1'b1, 1'b1, "hold ack rise");
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("floated in hold", 0, {ad_oe, addr_high_oe, rd_oe, wr_oe, io_m_oe});
		@(posedge clk_sys);
		general_irq <= 1'b1;
		repeat (8) @(posedge clk_sys);
		general_irq <= 1'b0;
		hold_req <= 1'b0;
		wait_on(1'b1, 1'b0, "hold ack fall");
		rd(`CBI_OFS_IRQ, q);
		chk("taken in hold", 13'h1800, q[12:0]);
		wr(`CBI_OFS_CMD, 32'h5);
		@(negedge clk_sys);
		chk("halt status", 0, {cycle_status1, cycle_status0});
		chk("floated in halt", 0, {addr_high_oe, rd_oe, wr_oe});
		@(posedge clk_sys);
		trap_in <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(`CBI_OFS_STAT, q);
		chk("halt ended by trap", 0, q[1]);
		chk("trap vector in halt", 8'h24, q[23:16]);
		trap_in <= 1'b0;
		wr(`CBI_OFS_MASK, 32'h308);
		do_reset;
		report_and_stop;
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		mismatches++;
		report_and_stop;
	end
endmodule // testbench
